/* jsd_top.sv */
// jsd_top: tap router with key unlock, boundary chain and debug frame decode.
// assumes test pins and the external tap return are asynchronous to CLK_SYS
// and that the test clock is much slower than CLK_SYS; OTP_CODE is static.
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1 - decode rom frame and processor debug frame
// RULE2 - unimplemented frame locations read zero, ignore writes
// RULE3 - rom table: unit pointer, reserved, terminator
// RULE4 - report router identification code over test port
// RULE5 - factory visible code leaves device unsecured
// RULE6 - xor code with key, tie-offs, exact compare
// RULE7 - programmer secures by clearing a code bit
// RULE8 - all-zero visible code keeps device secured forever
// RULE9 - instruction 1011 selects the scanned key register
// RULE10 - probe scans key restoring factory code
// RULE11 - only power-on reset clears scanned key
// RULE12 - secured: only key chain through tap two
// RULE13 - secured: other taps, test, boundary blocked
// RULE14 - boundary chain shifts from data in to out
// RULE15 - router reaches internal chains from test port
// RULE16 - tie-offs and match value never readable
// RULE17 - key uses capture, shift, update; compare updated
module jsd_top
   import jsd_pkg::*;
(
   input  wire logic                CLK_SYS,                // system clock, 50 MHz
   input  wire logic                RESET_N,                // power-on reset, async
   input  wire logic                TCK,                    // test clock pin
   input  wire logic                TMS,                    // test mode select pin
   input  wire logic                TDI,                    // test data in pin
   input  wire logic                TRST_N,                 // test logic reset pin
   output logic                     TDO,                    // test data out
   output logic                     TDO_OE,                 // high while driving TDO
   input  wire logic [KEY_W-1:0]    OTP_CODE,               // stored visible code
   output logic                     UNLOCK_GRANTED,         // device unsecured
   output logic                     STAP_SEL,               // other secondary tap sel
   output logic                     TEST_TAP_SEL,           // test tap select
   input  wire logic                STAP_TDO,               // return of external taps
   input  wire logic [BSC_LEN-1:0]  BS_PIN_IN,              // pin levels to capture
   output logic [BSC_LEN-1:0]       BS_PIN_OUT,             // boundary update values
   output logic                     BS_EXTEST,              // boundary drives pins
   input  wire jsd_dbg_req_type     DBG_REQ,                // debug bus request
   output logic                     DBG_ACK,                // answer pulse
   output logic [31:0]              DBG_RDATA,              // read data
   output logic                     DEBUG_ROM_FRAME_SELECT, // rom frame selected
   output logic                     CPU_DEBUG_FRAME_SELECT, // cpu frame selected
   input  wire logic [31:0]         CPU_RDATA               // cpu debug unit data
);

   // pin synchronisers; stage one feeds only stage two
   logic tck_s1_r, tck_s2_r, tck_s3_r;
   logic tms_s1_r, tms_s2_r;
   logic tdi_s1_r, tdi_s2_r;
   logic trst_s1_r, trst_s2_r;
   logic stdo_s1_r, stdo_s2_r;

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         {tck_s1_r, tck_s2_r, tck_s3_r} <= 3'h0;
         {tms_s1_r, tms_s2_r}           <= 2'h3;
         {tdi_s1_r, tdi_s2_r}           <= 2'h0;
         {trst_s1_r, trst_s2_r}         <= 2'h0;
         {stdo_s1_r, stdo_s2_r}         <= 2'h0;
      end else begin
         {tck_s1_r, tck_s2_r, tck_s3_r} <= {TCK, tck_s1_r, tck_s2_r};
         {tms_s1_r, tms_s2_r}           <= {TMS, tms_s1_r};
         {tdi_s1_r, tdi_s2_r}           <= {TDI, tdi_s1_r};
         {trst_s1_r, trst_s2_r}         <= {TRST_N, trst_s1_r};
         {stdo_s1_r, stdo_s2_r}         <= {STAP_TDO, stdo_s1_r};
      end
   end

   wire tck_rise = tck_s2_r & ~tck_s3_r;
   wire tck_fall = ~tck_s2_r & tck_s3_r;

   jsd_tap_state_type tap_state;

   jsd_tap_fsm u_fsm (
      .clk      (CLK_SYS),
      .rst_n    (RESET_N),
      .trst_n   (trst_s2_r),
      .tck_rise (tck_rise),
      .tms      (tms_s2_r),
      .state    (tap_state)
   );

   wire in_tlr = (tap_state == TS_RESET);
   wire cap_dr = tck_rise & (tap_state == TS_CAP_DR);
   wire sh_dr  = tck_rise & (tap_state == TS_SH_DR);
   wire up_dr  = tck_rise & (tap_state == TS_UP_DR);
   wire cap_ir = tck_rise & (tap_state == TS_CAP_IR);
   wire sh_ir  = tck_rise & (tap_state == TS_SH_IR);
   wire up_ir  = tck_rise & (tap_state == TS_UP_IR);

   // instruction register
   logic [IR_W-1:0] ir_sh_r, ir_r;

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         ir_sh_r <= IR_CAPTURE;
         ir_r    <= IR_RESET_VAL;
      end else if (in_tlr) begin
         ir_r    <= IR_RESET_VAL;
      end else begin
         if (cap_ir) ir_sh_r <= IR_CAPTURE;
         if (sh_ir)  ir_sh_r <= {tdi_s2_r, ir_sh_r[IR_W-1:1]};
         if (up_ir)  ir_r    <= ir_sh_r;
      end
   end

   // unlock evaluation
   logic unlock_r;
   wire [KEY_W-1:0] key_upd;
   wire [KEY_W-1:0] key_mix   = (OTP_CODE ^ key_upd) ^ TIE_OFF;       // [RULE6] [RULE16]
   wire             otp_blank = (OTP_CODE == {KEY_W{1'b0}});
   // an all-zero code can never match, whatever key is scanned
   wire             key_match = (key_mix == UNLOCK_MATCH) & ~otp_blank; // [RULE6] [RULE8] [RULE5]

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) unlock_r <= 1'b0;
      else          unlock_r <= key_match;
   end

   assign UNLOCK_GRANTED = unlock_r;

   // secured: every instruction but the key one acts as bypass
   wire [IR_W-1:0] ir_eff = unlock_r ? ir_r :
                            ((ir_r == IR_KEY) ? IR_KEY : IR_BYPASS); // [RULE12] [RULE13]

   wire sel_key  = (ir_eff == IR_KEY);                               // [RULE9]
   wire sel_id   = (ir_eff == IR_IDCODE);
   wire sel_bsc  = (ir_eff == IR_EXTEST) | (ir_eff == IR_SAMPLE);
   wire sel_stap = (ir_eff == IR_STAP_OTHER);
   wire sel_test = (ir_eff == IR_TEST_TAP);
   wire sel_ext  = sel_stap | sel_test;

   assign STAP_SEL     = sel_stap;                                   // [RULE13] [RULE15]
   assign TEST_TAP_SEL = sel_test;                                   // [RULE13]

   // scanned key register: only power-on reset clears it
   logic [KEY_W-1:0] key_sh_r, key_upd_r;

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin                                            // [RULE11]
         key_sh_r  <= {KEY_W{1'b0}};
         key_upd_r <= {KEY_W{1'b0}};
      end else if (sel_key) begin
         // capture zeros so the held key never scans back out
         if (cap_dr) key_sh_r  <= {KEY_W{1'b0}};                    // [RULE17]
         if (sh_dr)  key_sh_r  <= {tdi_s2_r, key_sh_r[KEY_W-1:1]};  // [RULE17]
         if (up_dr)  key_upd_r <= key_sh_r;                         // [RULE17]
      end
   end

   assign key_upd = key_upd_r;

   // identification and bypass
   logic [ID_W-1:0] id_sh_r;
   logic            byp_r;

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         id_sh_r <= ID_CODE;
         byp_r   <= 1'b0;
      end else begin
         if (cap_dr & sel_id) id_sh_r <= ID_CODE;                    // [RULE4]
         if (sh_dr & sel_id)  id_sh_r <= {tdi_s2_r, id_sh_r[ID_W-1:1]};
         if (cap_dr)          byp_r   <= 1'b0;
         if (sh_dr)           byp_r   <= tdi_s2_r;
      end
   end

   // boundary chain
   logic [BSC_LEN-1:0] bsc_sh_r, bsc_upd_r;

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         bsc_sh_r  <= {BSC_LEN{1'b0}};
         bsc_upd_r <= {BSC_LEN{1'b0}};
      end else if (sel_bsc) begin                                    // [RULE13]
         if (cap_dr) bsc_sh_r  <= BS_PIN_IN;
         if (sh_dr)  bsc_sh_r  <= {tdi_s2_r, bsc_sh_r[BSC_LEN-1:1]}; // [RULE14]
         if (up_dr)  bsc_upd_r <= bsc_sh_r;
      end
   end

   assign BS_PIN_OUT = bsc_upd_r;
   assign BS_EXTEST  = (ir_eff == IR_EXTEST);

   // serial output, changes on the falling test clock edge
   wire dr_out = sel_key  ? key_sh_r[0] :
                 sel_id   ? id_sh_r[0]  :
                 sel_bsc  ? bsc_sh_r[0] :                            // [RULE14]
                 sel_ext  ? stdo_s2_r   : byp_r;                     // [RULE15]
   wire in_sh_dr = (tap_state == TS_SH_DR);
   wire in_sh_ir = (tap_state == TS_SH_IR);

   logic tdo_r, tdo_oe_r;

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         tdo_r    <= 1'b0;
         tdo_oe_r <= 1'b0;
      end else if (tck_fall) begin
         tdo_r    <= in_sh_ir ? ir_sh_r[0] : dr_out;
         tdo_oe_r <= in_sh_ir | in_sh_dr;
      end
   end

   assign TDO    = tdo_r;
   assign TDO_OE = tdo_oe_r;

   // debug frame decode
   function automatic logic [31:0] rom_word(input logic [9:0] idx);
      case (idx)
         10'h000: rom_word = ROM_ENTRY0;
         10'h001: rom_word = ROM_ENTRY1;
         10'h002: rom_word = ROM_ENTRY2;
         10'h003: rom_word = ROM_ENTRY3;
         ROM_LAST_IDX: rom_word = ROM_ENTRY4;
         default: rom_word = 32'h0000_0000;
      endcase
   endfunction : rom_word

   wire rom_hit = DBG_REQ.sel & jsd_frame_hit(DBG_REQ.addr, ROM_FRAME_BASE); // [RULE1]
   wire cpu_hit = DBG_REQ.sel & jsd_frame_hit(DBG_REQ.addr, CPU_FRAME_BASE); // [RULE1]

   assign DEBUG_ROM_FRAME_SELECT = rom_hit;
   assign CPU_DEBUG_FRAME_SELECT = cpu_hit;

   // rom writes fall through with no effect
   wire [31:0] rd_nxt = DBG_REQ.wr ? 32'h0000_0000 :
                        rom_hit ? rom_word(DBG_REQ.addr[11:2]) :     // [RULE3] [RULE2]
                        cpu_hit ? CPU_RDATA : 32'h0000_0000;         // [RULE2]

   logic        ack_r;
   logic [31:0] rdata_r;

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         ack_r   <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else begin
         ack_r <= DBG_REQ.sel;
         if (DBG_REQ.sel) rdata_r <= rd_nxt;
      end
   end

   assign DBG_ACK   = ack_r;
   assign DBG_RDATA = rdata_r;

endmodule : jsd_top
`default_nettype wire

/* jsd_pkg.sv */
// jsd_pkg: constants, types and helpers shared by the debug-security block.
// assumes every user is clocked by the system clock at 50 MHz.
package jsd_pkg;

   localparam int unsigned  KEY_W    = 128;
   localparam int unsigned  IR_W     = 4;
   localparam int unsigned  ID_W     = 32;
   localparam int unsigned  BSC_LEN  = 8;

   // debug frames, 4KB each
   localparam logic [31:0]  ROM_FRAME_BASE = 32'hFFA0_0000;
   localparam logic [31:0]  CPU_FRAME_BASE = 32'hFFA0_1000;
   localparam logic [31:0]  FRAME_MASK     = 32'hFFFF_F000;
   localparam logic [9:0]   ROM_LAST_IDX   = 10'h004;

   // debug rom table entries; entry 4 terminates the table
   localparam logic [31:0]  ROM_ENTRY0 = 32'h0000_1003;
   localparam logic [31:0]  ROM_ENTRY1 = 32'h0000_2002;
   localparam logic [31:0]  ROM_ENTRY2 = 32'h0000_3002;
   localparam logic [31:0]  ROM_ENTRY3 = 32'h0000_4003;
   localparam logic [31:0]  ROM_ENTRY4 = 32'h0000_0000;

   // instruction codes of the shared instruction register
   localparam logic [3:0]   IR_EXTEST     = 4'h0;
   localparam logic [3:0]   IR_SAMPLE     = 4'h1;
   localparam logic [3:0]   IR_IDCODE     = 4'h2;
   localparam logic [3:0]   IR_STAP_OTHER = 4'h4;
   localparam logic [3:0]   IR_TEST_TAP   = 4'h8;
   localparam logic [3:0]   IR_KEY        = 4'hB;
   localparam logic [3:0]   IR_BYPASS     = 4'hF;
   localparam logic [3:0]   IR_CAPTURE    = 4'h1;
   localparam logic [3:0]   IR_RESET_VAL  = IR_IDCODE;

   // identification code: value is arbitrary, lsb must stay 1
   localparam logic [31:0]  ID_CODE = 32'h0A5A_5001;

   // visible unlock code lives in otp at this address; erased otp reads ones
   localparam logic [31:0]     OTP_CODE_ADDR = 32'hF000_0000;
   localparam logic [KEY_W-1:0] FACTORY_CODE = {KEY_W{1'b1}};
   // internal tie-offs and comparison value; never placed on any chain
   localparam logic [KEY_W-1:0] TIE_OFF =
      128'h5A3C_96E1_0F87_2B4D_C3A5_7E19_D26B_84F0;
   localparam logic [KEY_W-1:0] UNLOCK_MATCH = FACTORY_CODE ^ TIE_OFF;

   typedef enum logic [15:0] {
      TS_RESET  = 16'h0001, TS_IDLE   = 16'h0002, TS_SEL_DR = 16'h0004,
      TS_CAP_DR = 16'h0008, TS_SH_DR  = 16'h0010, TS_EX1_DR = 16'h0020,
      TS_PA_DR  = 16'h0040, TS_EX2_DR = 16'h0080, TS_UP_DR  = 16'h0100,
      TS_SEL_IR = 16'h0200, TS_CAP_IR = 16'h0400, TS_SH_IR  = 16'h0800,
      TS_EX1_IR = 16'h1000, TS_PA_IR  = 16'h2000, TS_EX2_IR = 16'h4000,
      TS_UP_IR  = 16'h8000
   } jsd_tap_state_type;

   typedef struct packed {
      logic        sel;
      logic        wr;
      logic [31:0] addr;
      logic [31:0] wdata;
   } jsd_dbg_req_type;

   function automatic logic jsd_frame_hit(input logic [31:0] addr,
                                          input logic [31:0] base);
      return (addr & FRAME_MASK) == base;
   endfunction : jsd_frame_hit

endpackage : jsd_pkg

/* jsd_tap_fsm.sv */
// jsd_tap_fsm: sixteen-state test access port controller.
// assumes tck_rise marks a sampled rising test clock edge and tms is aligned to it.
`timescale 1ns/1ps
`default_nettype none
module jsd_tap_fsm
   import jsd_pkg::*;
(
   input  wire logic              clk,       // system clock
   input  wire logic              rst_n,     // power-on reset, async
   input  wire logic              trst_n,    // synchronised test reset
   input  wire logic              tck_rise,  // one-cycle test clock rise
   input  wire logic              tms,       // synchronised mode select
   output jsd_tap_state_type      state      // current controller state
);

   jsd_tap_state_type state_r;
   jsd_tap_state_type state_nxt;

   assign state = state_r;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         TS_RESET:  state_nxt = tms ? TS_RESET  : TS_IDLE;
         TS_IDLE:   state_nxt = tms ? TS_SEL_DR : TS_IDLE;
         TS_SEL_DR: state_nxt = tms ? TS_SEL_IR : TS_CAP_DR;
         TS_CAP_DR: state_nxt = tms ? TS_EX1_DR : TS_SH_DR;
         TS_SH_DR:  state_nxt = tms ? TS_EX1_DR : TS_SH_DR;
         TS_EX1_DR: state_nxt = tms ? TS_UP_DR  : TS_PA_DR;
         TS_PA_DR:  state_nxt = tms ? TS_EX2_DR : TS_PA_DR;
         TS_EX2_DR: state_nxt = tms ? TS_UP_DR  : TS_SH_DR;
         TS_UP_DR:  state_nxt = tms ? TS_SEL_DR : TS_IDLE;
         TS_SEL_IR: state_nxt = tms ? TS_RESET  : TS_CAP_IR;
         TS_CAP_IR: state_nxt = tms ? TS_EX1_IR : TS_SH_IR;
         TS_SH_IR:  state_nxt = tms ? TS_EX1_IR : TS_SH_IR;
         TS_EX1_IR: state_nxt = tms ? TS_UP_IR  : TS_PA_IR;
         TS_PA_IR:  state_nxt = tms ? TS_EX2_IR : TS_PA_IR;
         TS_EX2_IR: state_nxt = tms ? TS_UP_IR  : TS_SH_IR;
         TS_UP_IR:  state_nxt = tms ? TS_SEL_DR : TS_IDLE;
         default:   state_nxt = TS_RESET;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= TS_RESET;
      end else if (!trst_n) begin
         state_r <= TS_RESET;
      end else if (tck_rise) begin
         state_r <= state_nxt;
      end
   end

endmodule : jsd_tap_fsm
`default_nettype wire

/* jsd_top_monitor.sv */
// jsd_top_monitor: port-level assertions for the debug-security block.
// assumes one CLK_SYS domain reset by RESET_N; test pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module jsd_top_monitor
   import jsd_pkg::*;
(
   input wire logic             CLK_SYS,                // clock
   input wire logic             RESET_N,                // reset
   input wire logic             TCK,                    // link clock
   input wire logic             TDO,                    // serial out
   input wire logic             TDO_OE,                 // serial out enable
   input wire logic [KEY_W-1:0] OTP_CODE,               // stored code
   input wire logic             UNLOCK_GRANTED,         // unsecured
   input wire logic             STAP_SEL,               // other tap
   input wire logic             TEST_TAP_SEL,           // test tap
   input wire logic             BS_EXTEST,              // boundary drive
   input wire jsd_dbg_req_type  DBG_REQ,                // bus request
   input wire logic             DBG_ACK,                // answer
   input wire logic [31:0]      DBG_RDATA,              // read data
   input wire logic             DEBUG_ROM_FRAME_SELECT, // rom frame
   input wire logic             CPU_DEBUG_FRAME_SELECT, // cpu frame
   input wire logic [31:0]      CPU_RDATA               // cpu data
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);
   sequence rd_in(base);
      DBG_REQ.sel && !DBG_REQ.wr && ((DBG_REQ.addr & 32'hFFFF_F000) == base);
   endsequence
   sequence wr_req;
      DBG_REQ.sel && DBG_REQ.wr;
   endsequence
   ack_after_req_a: assert property (DBG_REQ.sel |=> DBG_ACK)
      else $error("debug request without answer");
   ack_has_cause_a: assert property (DBG_ACK |-> $past(DBG_REQ.sel))
      else $error("answer without request");
   rom_select_a: assert property (DEBUG_ROM_FRAME_SELECT ==
      (DBG_REQ.sel && ((DBG_REQ.addr & 32'hFFFF_F000) == 32'hFFA0_0000)))
      else $error("rom frame select wrong");
   cpu_select_a: assert property (CPU_DEBUG_FRAME_SELECT ==
      (DBG_REQ.sel && ((DBG_REQ.addr & 32'hFFFF_F000) == 32'hFFA0_1000)))
      else $error("cpu frame select wrong");
   rom_pointer_a: assert property ((rd_in(32'hFFA0_0000)
      and DBG_REQ.addr[11:0] == 12'h000) |=> DBG_RDATA == 32'h0000_1003)
      else $error("rom entry zero wrong");
   write_quiet_a: assert property (wr_req |=> DBG_RDATA == 32'h0000_0000)
      else $error("write returned data");
   cpu_pass_a: assert property (rd_in(32'hFFA0_1000) |=> DBG_RDATA == $past(CPU_RDATA))
      else $error("cpu frame data wrong");
   locked_taps_a: assert property (!UNLOCK_GRANTED |->
      !STAP_SEL && !TEST_TAP_SEL && !BS_EXTEST)
      else $error("tap reachable while secured");
   zero_code_a: assert property (OTP_CODE == '0 |-> !UNLOCK_GRANTED)
      else $error("all-zero code unlocked");
   tdo_on_fall_a: assert property ($changed(TDO) |-> !$past(TCK))
      else $error("serial out moved while link clock high");
   oe_on_fall_a: assert property ($changed(TDO_OE) |-> !$past(TCK))
      else $error("serial enable moved while link clock high");
endmodule : jsd_top_monitor
bind jsd_top jsd_top_monitor jsd_top_monitor_inst (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
   .TCK(TCK), .TDO(TDO), .TDO_OE(TDO_OE), .OTP_CODE(OTP_CODE),
   .UNLOCK_GRANTED(UNLOCK_GRANTED),
   .STAP_SEL(STAP_SEL), .TEST_TAP_SEL(TEST_TAP_SEL), .BS_EXTEST(BS_EXTEST),
   .DBG_REQ(DBG_REQ), .DBG_ACK(DBG_ACK), .DBG_RDATA(DBG_RDATA), .CPU_RDATA(CPU_RDATA),
   .DEBUG_ROM_FRAME_SELECT(DEBUG_ROM_FRAME_SELECT),
   .CPU_DEBUG_FRAME_SELECT(CPU_DEBUG_FRAME_SELECT));
`default_nettype wire

/* jsd_probe.sv */
// jsd_probe: behavioural test-port probe on the far side of the link.
// assumes a 160 ns link clock that idles low between frames.
`timescale 1ns/1ps
`default_nettype none
module jsd_probe (
   output var logic  TCK,    // link clock
   output var logic  TMS,    // mode select
   output var logic  TDI,    // data in
   output var logic  TRST_N, // link reset
   input  wire logic TDO     // data out
);
   initial begin
      TCK = 1'b0;
      TMS = 1'b1;
      TDI = 1'b0;
      TRST_N = 1'b1;
   end
   // serial out is taken just before the rise, long after the last fall
   task automatic step(input logic ms, input logic di, output logic q);
      TMS = ms;
      TDI = di;
      #80;
      q = TDO;
      TCK = 1'b1;
      #80;
      TCK = 1'b0;
   endtask : step
   task automatic idle();
      logic q;
      repeat (5) step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
   endtask : idle
   task automatic trst();
      logic q;
      TRST_N = 1'b0;
      #400;
      TRST_N = 1'b1;
      #400;
      step(1'b0, 1'b0, q);
   endtask : trst
   task automatic scan(input logic ir, input logic [127:0] din, input int n,
                       output logic [127:0] dout);
      logic q;
      dout = '0;
      step(1'b1, 1'b0, q);
      if (ir) step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
      step(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, ~din[n-1], q);
      step(1'b0, din[n-1], q);
      TDI = ~TDI; // a released line must not keep its last value
      // half a period of rest so the update has reached every flop
      #80;
   endtask : scan
   task automatic unlock(input logic [127:0] key);
      logic [127:0] d;
      scan(1'b1, 128'h0000_000B, 4, d);
      scan(1'b0, key, 128, d);
   endtask : unlock
endmodule : jsd_probe
`default_nettype wire

/* test_jtag_security_debug_access.sv */
// test_jtag_security_debug_access: self-checking bench for jsd_top.
// assumes jsd_probe drives the link pins and the bench all other inputs.
`timescale 1ns/1ps
`default_nettype none
module test_jtag_security_debug_access
   import jsd_pkg::*;
;
   logic               CLK_SYS = 1'b0, RESET_N = 1'b0, STAP_TDO = 1'b0;
   wire logic          TCK, TMS, TDI, TRST_N;
   logic               TDO, TDO_OE, UNLOCK_GRANTED, STAP_SEL, TEST_TAP_SEL, BS_EXTEST;
   logic               DBG_ACK, DEBUG_ROM_FRAME_SELECT, CPU_DEBUG_FRAME_SELECT;
   logic [KEY_W-1:0]   OTP_CODE = FACTORY_CODE, d, otp;
   logic [BSC_LEN-1:0] BS_PIN_IN = '0, BS_PIN_OUT;
   jsd_dbg_req_type    DBG_REQ = '0;
   logic [31:0]        DBG_RDATA, r, CPU_RDATA = '0, exp_q[$];
   int                 n_mismatch = 0, n_tests = 0;
   always #10 CLK_SYS = ~CLK_SYS;
   jsd_top jsd_top_inst (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .TCK(TCK), .TMS(TMS),
      .TDI(TDI), .TRST_N(TRST_N), .TDO(TDO), .TDO_OE(TDO_OE), .OTP_CODE(OTP_CODE),
      .UNLOCK_GRANTED(UNLOCK_GRANTED), .STAP_SEL(STAP_SEL), .TEST_TAP_SEL(TEST_TAP_SEL),
      .STAP_TDO(STAP_TDO), .BS_PIN_IN(BS_PIN_IN), .BS_PIN_OUT(BS_PIN_OUT),
      .BS_EXTEST(BS_EXTEST), .DBG_REQ(DBG_REQ), .DBG_ACK(DBG_ACK), .DBG_RDATA(DBG_RDATA),
      .DEBUG_ROM_FRAME_SELECT(DEBUG_ROM_FRAME_SELECT), .CPU_RDATA(CPU_RDATA),
      .CPU_DEBUG_FRAME_SELECT(CPU_DEBUG_FRAME_SELECT));
   jsd_probe jsd_probe_inst (.TCK(TCK), .TMS(TMS), .TDI(TDI), .TRST_N(TRST_N), .TDO(TDO));
   task automatic check(input logic [127:0] got, input logic [127:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // an answer with nothing noted compares against unknown and fails
   always @(posedge CLK_SYS) begin
      if (DBG_ACK === 1'b1) check(DBG_RDATA, exp_q.size() ? exp_q.pop_front() : 'x);
   end
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] exp);
      @(posedge CLK_SYS);
      DBG_REQ <= '{sel: 1'b1, wr: wr, addr: a, wdata: $urandom};
      CPU_RDATA <= r;
      exp_q.push_back(exp);
   endtask : bus
   task automatic do_reset(input logic [127:0] code);
      @(posedge CLK_SYS);
      RESET_N <= 1'b0;
      OTP_CODE <= code;
      repeat (3) @(posedge CLK_SYS);
      RESET_N <= 1'b1;
      repeat (3) @(posedge CLK_SYS);
      jsd_probe_inst.idle();
   endtask : do_reset
   task automatic codes(input logic on);
      logic [3:0] c [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hF};
      for (int i = 0; i < 6; i++) begin
         jsd_probe_inst.scan(1'b1, 128'(c[i]), 4, d);
         check(d, 128'h0000_0001);
         check({STAP_SEL, TEST_TAP_SEL, BS_EXTEST},
            {on && c[i] == 4'h4, on && c[i] == 4'h8, on && c[i] == 4'h0});
      end
   endtask : codes
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize
   initial begin
      #400_000;
      n_mismatch++;
      summarize();
   end
   initial begin
      logic [31:0] rom [6];
      rom = '{32'h0000_1003, 32'h0000_2002, 32'h0000_3002, 32'h0000_4003, 32'h0, 32'h0};
      void'($urandom(32'h402176a0));
      do_reset(FACTORY_CODE);
      check(UNLOCK_GRANTED, 1'b1);
      jsd_probe_inst.scan(1'b0, 128'h0, 32, d);
      check(d, 128'(ID_CODE));
      r = $urandom;
      for (int i = 0; i < 6; i++) bus(1'b0, ROM_FRAME_BASE + 32'(i * 4), rom[i]);
      bus(1'b0, ROM_FRAME_BASE + 32'(($urandom % 1000 + 5) * 4), 32'h0);
      bus(1'b1, ROM_FRAME_BASE, 32'h0);
      bus(1'b0, ROM_FRAME_BASE, rom[0]);
      bus(1'b0, CPU_FRAME_BASE + ($urandom & 32'h0000_0FFC), r);
      bus(1'b0, 32'hFFA0_2000, 32'h0);
      @(posedge CLK_SYS) DBG_REQ <= '0;
      repeat (3) @(posedge CLK_SYS);
      check(exp_q.size(), 0);
      codes(1'b1);
      @(posedge CLK_SYS) STAP_TDO <= 1'b1;
      jsd_probe_inst.scan(1'b1, 128'h4, 4, d);
      jsd_probe_inst.scan(1'b0, 128'h0, 8, d);
      check(d, 128'hFF);
      @(posedge CLK_SYS) BS_PIN_IN <= 8'($urandom);
      jsd_probe_inst.scan(1'b1, 128'h0, 4, d);
      otp = 128'($urandom);
      jsd_probe_inst.scan(1'b0, otp, 8, d);
      check(d, BS_PIN_IN);
      check(BS_PIN_OUT, otp[7:0]);
      otp = FACTORY_CODE;
      otp[$urandom % 128] = 1'b0;
      do_reset(otp);
      check(UNLOCK_GRANTED, 1'b0);
      codes(1'b0);
      jsd_probe_inst.scan(1'b1, 128'h2, 4, d);
      jsd_probe_inst.scan(1'b0, 128'h0, 32, d);
      check(d, 128'h0);
      jsd_probe_inst.unlock(~otp ^ 128'h1);
      check(UNLOCK_GRANTED, 1'b0);
      jsd_probe_inst.unlock(~otp);
      check(UNLOCK_GRANTED, 1'b1);
      jsd_probe_inst.trst();
      check(UNLOCK_GRANTED, 1'b1);
      do_reset(otp);
      check(UNLOCK_GRANTED, 1'b0);
      do_reset('0);
      jsd_probe_inst.unlock('1);
      check(UNLOCK_GRANTED, 1'b0);
      summarize();
   end
endmodule : test_jtag_security_debug_access
`default_nettype wire
